// ===== hw/fcpr_pkg.sv
// Constants, opcodes and types shared by the flash configuration block.
package fcpr_pkg;

  // Sector geometry of the protected array.
  localparam int SECTORS  = 16;
  localparam int SUBS     = 16;
  localparam int VL_N     = 2 * SUBS + SECTORS - 2;
  localparam int SECT_LSB = 16;
  localparam int SUB_LSB  = 12;
  localparam logic [3:0] SECT_LAST = 4'hF;

  // Volatile configuration register layout and reset value.
  localparam int VCFG_QUAD = 7;
  localparam int VCFG_DUAL = 6;
  localparam int VCFG_DTR  = 5;
  localparam int VCFG_HOLD = 4;
  localparam int VCFG_FIX  = 3;
  localparam int VCFG_DRV0 = 0;
  localparam logic [7:0] VCFG_RST   = 8'hFF;
  localparam logic [7:0] VCFG_PROTO = 8'hE0;

  // Output drive codes; codes with bit 0 clear are reserved.
  localparam logic [2:0] DRV_90_OHM = 3'h1;
  localparam logic [2:0] DRV_45_OHM = 3'h3;
  localparam logic [2:0] DRV_20_OHM = 3'h5;
  localparam logic [2:0] DRV_30_OHM = 3'h7;

  // Sector protection register layout.
  localparam int PROT_PWD  = 2;
  localparam int PROT_SECT = 1;
  localparam logic [15:0] PROT_RST   = 16'hFFFF;
  localparam logic [15:0] PROT_FIXED = 16'hFFF9;
  localparam logic [63:0] PWD_RST    = 64'hFFFF_FFFF_FFFF_FFFF;

  // Serial command opcodes.
  localparam logic [7:0] OP_WR_VCFG = 8'h11;
  localparam logic [7:0] OP_RD_VCFG = 8'h12;
  localparam logic [7:0] OP_WR_PROT = 8'h21;
  localparam logic [7:0] OP_RD_PROT = 8'h22;
  localparam logic [7:0] OP_WR_PWD  = 8'h31;
  localparam logic [7:0] OP_RD_PWD  = 8'h32;
  localparam logic [7:0] OP_UNLOCK  = 8'h33;
  localparam logic [7:0] OP_WR_FRZ  = 8'h41;
  localparam logic [7:0] OP_RD_FRZ  = 8'h42;
  localparam logic [7:0] OP_WR_NV   = 8'h51;
  localparam logic [7:0] OP_RD_NV   = 8'h52;
  localparam logic [7:0] OP_ER_NV   = 8'h53;
  localparam logic [7:0] OP_WR_VL   = 8'h61;
  localparam logic [7:0] OP_RD_VL   = 8'h62;
  localparam logic [7:0] OP_SOFT_RST = 8'h99;
  localparam logic [7:0] OP_RESCUE  = 8'hFF;

  // Frame lengths in serial clocks, and read timing points.
  localparam logic [6:0] LEN_OP     = 7'h08;
  localparam logic [6:0] LEN_BYTE   = 7'h10;
  localparam logic [6:0] LEN_HALF   = 7'h18;
  localparam logic [6:0] LEN_ADDR   = 7'h20;
  localparam logic [6:0] LEN_ADDR_B = 7'h28;
  localparam logic [6:0] LEN_PWD    = 7'h48;
  localparam logic [6:0] LEN_DUMMY  = 7'h08;
  localparam logic [6:0] CNT_MAX    = 7'h7F;

  // Command protocol in effect.
  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} fcpr_proto_t;

endpackage

// ===== hw/fcpr_regs.sv
// Configuration and protection registers behind a serial command link.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - VCFG bit 7 low enables quad command input; resets high.
// - VCFG bit 6 low enables dual command input; resets high.
// - Both protocol bits low selects quad protocol.
// - New protocol takes effect right after the write command.
// - Reset, rescue or rewrite returns the protocol to default.
// - VCFG bit 5 low selects double transfer rate; resets high.
// - VCFG bit 4 enables hold/reset on data line 3; default on.
// - Bit 3 reads one; drive field codes 1,3,5,7; default 7.
// - Any read or write of VCFG copies it into internal settings.
// - Protection register is 16 bits; only bits 2:1 active.
// - Clearing bit 2 enables password mode; password then hidden, fixed.
// - Bits 2 and 1 are one-time, at most one may be cleared.
// - Clearing bit 1 keeps bit 2 high forever.
// - In password mode freeze rises only with the correct password.
// - Freeze high allows lock bit changes; bits 7:1 read zero.
// - In password mode freeze comes up locked at every reset.
// - Unlock sets freeze, write-freeze clears it, read returns it.
// - One nonvolatile lock bit per sector, protects until erased.
// - Volatile lock bits clear on reset.
// - First and last sectors have volatile locks per 4KB subsector.
// - Nonvolatile bit low or volatile bit high blocks program/erase.
module fcpr_regs
  import fcpr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        factory_erase,
  // Serial link
  input  wire logic        link_sclk,
  input  wire logic        link_cs_n,
  input  wire logic        link_din,
  output var  logic        link_dout,
  output var  logic        link_dout_oe,
  // Program and erase gate
  input  wire logic [23:0] pe_addr,
  output var  logic        pe_blocked,
  // Settings in effect
  output var  fcpr_proto_t proto_mode,
  output var  logic        dtr_mode,
  output var  logic        data_line_3_hold_en,
  output var  logic [2:0]  drive_code,
  output var  logic        nv_lock_writable,
  output var  logic        pwd_prot_on
);

  // Maps an address to its volatile lock entry. The two end sectors own
  // one entry per 4KB subsector at the bottom of the table, and every
  // other sector has one entry of its own, in the run that follows them.
  function automatic logic [5:0] vl_index(input logic [23:0] a);
    logic [3:0] s;
    logic [3:0] b;
    s = a[SECT_LSB +: 4];
    b = a[SUB_LSB +: 4];
    if (s == 4'h0) begin
      vl_index = {2'h0, b};
    end else if (s == SECT_LAST) begin
      vl_index = {2'h1, b};
    end else begin
      vl_index = 6'(2 * SUBS) + {2'h0, s} - 6'h1;
    end
  endfunction

  // Link clock domain. The serial clock only runs inside a frame, so
  // everything here is quiet once the frame is deselected; the reference
  // side reads the command bytes only after it has seen the deselect or a
  // read request through its own synchroniser, when they can no longer move.
  logic [6:0]  cnt_q;
  logic [6:0]  len_q;
  logic [71:0] sr_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic        req_q;
  logic        ack_s1_q;
  logic        ack_s2_q;
  logic [63:0] tx_q;
  logic        tx_on_q;
  logic        dout_q;
  logic        oe_q;
  // Read answer held on the reference side, declared here for the loader.
  logic        ack_q;
  logic [63:0] rd_word_q;

  // Opcode as soon as its last bit arrives, and the read timing points.
  // Short reads answer after the opcode, address reads after the address.
  wire logic [7:0] op_w = (cnt_q == LEN_OP - 7'h1) ?
                          {sr_q[6:0], link_din} : op_q;
  wire logic rd_short_w = (op_w == OP_RD_VCFG) || (op_w == OP_RD_PROT) ||
                          (op_w == OP_RD_PWD) || (op_w == OP_RD_FRZ);
  wire logic rd_addr_w  = (op_w == OP_RD_NV) || (op_w == OP_RD_VL);
  wire logic [6:0] rd_at_w = rd_addr_w ? LEN_ADDR : LEN_OP;
  wire logic req_pt_w = (rd_short_w || rd_addr_w) &&
                        (cnt_q == rd_at_w - 7'h1);
  wire logic tx_pt_w  = (rd_short_w || rd_addr_w) &&
                        (cnt_q == rd_at_w + LEN_DUMMY - 7'h1);
  wire logic [6:0] cnt_inc_w = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 7'h1;

  // Bit counter restarts whenever the frame is deselected.
  always_ff @(posedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      cnt_q   <= 7'h00;
      tx_on_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_inc_w;
      tx_on_q <= tx_on_q | tx_pt_w;
    end
  end

  // Shift in command bytes; they stay put once the clock stops. The read
  // word is loaded only when the acknowledge has come back, so a host
  // clocking too fast gets zeros rather than a half-settled word.
  always_ff @(posedge link_sclk) begin
    sr_q  <= {sr_q[70:0], link_din};
    len_q <= cnt_inc_w;
    if (cnt_q == LEN_OP - 7'h1) begin
      op_q <= op_w;
    end
    if (cnt_q == LEN_ADDR - 7'h1) begin
      addr_q <= {sr_q[22:0], link_din};
    end
    if (tx_pt_w) begin
      tx_q <= (ack_s2_q == req_q) ? rd_word_q : 64'h0;
    end else begin
      tx_q <= {tx_q[62:0], 1'b0};
    end
  end

  // Read request toggle and the synchronised acknowledge. A toggle rather
  // than a pulse survives the slow serial clock, and only the second
  // acknowledge flop is read by the loader.
  always_ff @(posedge link_sclk or posedge rst) begin
    if (rst) begin
      req_q    <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      req_q    <= req_q ^ req_pt_w;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // Read data changes on the falling edge so the host samples it rising.
  // Deselect clears both flops at once so the line is quiet between frames.
  always_ff @(negedge link_sclk or posedge link_cs_n) begin
    if (link_cs_n) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      dout_q <= tx_q[63];
      oe_q   <= tx_on_q;
    end
  end

  assign link_dout    = dout_q;
  assign link_dout_oe = oe_q;

  // Reference clock domain. Commands act on the synchronised deselect
  // and read the frozen link registers then; a host that restarts a frame
  // within three reference cycles of the deselect would race them.
  logic        cs_s1_q;
  logic        cs_s2_q;
  logic        cs_s3_q;
  logic        req_s1_q;
  logic        req_s2_q;
  logic        req_s3_q;
  logic [7:0]  vcfg_q;
  logic [7:0]  cfg_q;
  fcpr_proto_t proto_q;
  logic [15:0] prot_q;
  logic [63:0] pwd_q;
  logic        frz_q;
  logic [SECTORS-1:0] nv_q;
  logic [VL_N-1:0]    vwl_q;
  logic [VL_N-1:0]    vld_q;
  logic        pe_blk_q;
  logic        dtr_q;
  logic        pwd_on_q;

  // Frame end and read request events, taken after two flip-flops.
  // The third flop only marks the edge; only the second flop reads the first one.
  wire logic fend_w = cs_s2_q & ~cs_s3_q;
  wire logic rreq_w = req_s2_q ^ req_s3_q;

  // Command decode at frame end; write commands need their exact length.
  // A write frame cut short or overrun leaves every register untouched.
  wire logic wr_vcfg_w = fend_w && op_q == OP_WR_VCFG && len_q == LEN_BYTE;
  wire logic rd_vcfg_w = fend_w && op_q == OP_RD_VCFG;
  wire logic wr_prot_w = fend_w && op_q == OP_WR_PROT && len_q == LEN_HALF;
  wire logic wr_pwd_w  = fend_w && op_q == OP_WR_PWD && len_q == LEN_PWD;
  wire logic unlock_w  = fend_w && op_q == OP_UNLOCK && len_q == LEN_PWD;
  wire logic wr_frz_w  = fend_w && op_q == OP_WR_FRZ && len_q == LEN_OP;
  wire logic wr_nv_w   = fend_w && op_q == OP_WR_NV && len_q == LEN_ADDR;
  wire logic er_nv_w   = fend_w && op_q == OP_ER_NV && len_q == LEN_OP;
  wire logic wr_vl_w   = fend_w && op_q == OP_WR_VL && len_q == LEN_ADDR_B;
  wire logic srst_w    = fend_w && op_q == OP_SOFT_RST && len_q == LEN_OP;
  wire logic rescue_w  = fend_w && op_q == OP_RESCUE && len_q == LEN_OP;
  wire logic vrst_w    = rst | srst_w;

  // New configuration byte; fixed bit forced, reserved drive codes kept.
  wire logic [7:0] wdat_w = sr_q[7:0];
  wire logic drv_ok_w = wdat_w[VCFG_DRV0];
  wire logic [7:0] vcfg_new_w = {wdat_w[7:4], 1'b1,
                                 drv_ok_w ? wdat_w[2:0] : vcfg_q[2:0]};
  wire logic [7:0] vcfg_d = vrst_w ? VCFG_RST :
                            wr_vcfg_w ? vcfg_new_w :
                            rescue_w ? (vcfg_q | VCFG_PROTO) : vcfg_q;
  wire logic [7:0] cfg_d = vrst_w ? VCFG_RST :
                           wr_vcfg_w ? vcfg_new_w :
                           rescue_w ? (cfg_q | VCFG_PROTO) :
                           rd_vcfg_w ? vcfg_q : cfg_q;

  // Quad wins when both protocol bits are low.
  // Dual applies only while quad is off.
  wire fcpr_proto_t proto_d = !cfg_d[VCFG_QUAD] ? PROTO_QUAD :
                              !cfg_d[VCFG_DUAL] ? PROTO_DUAL :
                              PROTO_EXT;

  // One-time protection bits only fall, and never both.
  wire logic [15:0] prot_new_w = (prot_q & sr_q[15:0]) | PROT_FIXED;
  wire logic prot_ok_w = prot_new_w[PROT_PWD] | prot_new_w[PROT_SECT];
  wire logic pwd_mode_w = ~prot_q[PROT_PWD];
  wire logic pwd_match_w = sr_q[63:0] == pwd_q;

  // Sector and volatile entry addressed by the current command.
  // The command address is frozen with the frame, like the opcode.
  wire logic [3:0] cmd_sect_w = addr_q[SECT_LSB +: 4];
  wire logic [5:0] cmd_vl_w   = vl_index(addr_q);
  wire logic [3:0] pe_sect_w  = pe_addr[SECT_LSB +: 4];
  wire logic [5:0] pe_vl_w    = vl_index(pe_addr);

  // Read data for the request, aligned to the first bit sent.
  // Unknown read opcodes return zeros.
  wire logic [7:0] nv_byte_w = nv_q[cmd_sect_w] ? 8'hFF : 8'h00;
  wire logic [7:0] vl_byte_w = {6'h00, vld_q[cmd_vl_w], vwl_q[cmd_vl_w]};
  wire logic [63:0] rd_sel_w =
    (op_q == OP_RD_VCFG) ? {vcfg_q, 56'h0} :
    (op_q == OP_RD_PROT) ? {prot_q, 48'h0} :
    (op_q == OP_RD_PWD)  ? (pwd_mode_w ? PWD_RST : pwd_q) :
    (op_q == OP_RD_FRZ)  ? {7'h00, frz_q, 56'h0} :
    (op_q == OP_RD_NV)   ? {nv_byte_w, 56'h0} :
    (op_q == OP_RD_VL)   ? {vl_byte_w, 56'h0} : 64'h0;

  // Synchronisers for deselect and the read request toggle. They reset
  // to the idle levels of their sources so that leaving reset never
  // looks like a frame end.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
    end else begin
      cs_s1_q  <= link_cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
    end
  end

  // Answer each read request with a held word and an acknowledge toggle.
  // The word is captured before the acknowledge can reach the link side,
  // so the loader never sees it change.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q     <= 1'b0;
      rd_word_q <= 64'h0;
    end else if (rreq_w) begin
      ack_q     <= req_s2_q;
      rd_word_q <= rd_sel_w;
    end
  end

  // Volatile configuration and the settings copied from it. The rate
  // flag is kept in its own flop so that the output needs no inverter.
  always_ff @(posedge ref_clk) begin
    vcfg_q  <= vcfg_d;
    cfg_q   <= cfg_d;
    proto_q <= proto_d;
    dtr_q   <= ~cfg_d[VCFG_DTR];
  end

  // Nonvolatile protection register and password.
  // Only a factory erase restores them; the design reset leaves them be.
  always_ff @(posedge ref_clk) begin
    if (factory_erase) begin
      prot_q   <= PROT_RST;
      pwd_q    <= PWD_RST;
      pwd_on_q <= 1'b0;
    end else begin
      if (wr_prot_w && prot_ok_w) begin
        prot_q   <= prot_new_w;
        pwd_on_q <= ~prot_new_w[PROT_PWD];
      end
      if (wr_pwd_w && !pwd_mode_w) begin
        pwd_q <= sr_q[63:0];
      end
    end
  end

  // Freeze bit: locked at reset in password mode, raised by unlock.
  // An erase held with reset brings it up open, as on a fresh part.
  always_ff @(posedge ref_clk) begin
    if (vrst_w) begin
      frz_q <= factory_erase | ~pwd_mode_w;
    end else if (unlock_w && (!pwd_mode_w || pwd_match_w)) begin
      frz_q <= 1'b1;
    end else if (wr_frz_w) begin
      frz_q <= 1'b0;
    end
  end

  // Nonvolatile sector locks change only while freeze is high, or on a factory erase.
  // Erase opens every sector at once; a write locks one sector.
  always_ff @(posedge ref_clk) begin
    if (factory_erase) begin
      nv_q <= '1;
    end else if (er_nv_w && frz_q) begin
      nv_q <= '1;
    end else if (wr_nv_w && frz_q) begin
      nv_q[cmd_sect_w] <= 1'b0;
    end
  end

  // Volatile locks clear on reset; lock-down freezes an entry.
  // A locked-down entry ignores further writes until the next reset.
  always_ff @(posedge ref_clk) begin
    if (vrst_w) begin
      vwl_q <= '0;
      vld_q <= '0;
    end else if (wr_vl_w && !vld_q[cmd_vl_w]) begin
      vwl_q[cmd_vl_w] <= wdat_w[0];
      vld_q[cmd_vl_w] <= wdat_w[1];
    end
  end

  // Program and erase gate for the requested address.
  // The answer follows a new address one reference cycle later.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pe_blk_q <= 1'b0;
    end else begin
      pe_blk_q <= ~nv_q[pe_sect_w] | vwl_q[pe_vl_w];
    end
  end

  // Settings in effect, all taken from flip-flops.
  assign proto_mode          = proto_q;
  assign dtr_mode            = dtr_q;
  assign data_line_3_hold_en = cfg_q[VCFG_HOLD];
  assign drive_code          = cfg_q[2:0];
  assign nv_lock_writable    = frz_q;
  assign pwd_prot_on         = pwd_on_q;
  assign pe_blocked          = pe_blk_q;

endmodule

`default_nettype wire

// ===== test/fcpr_host.sv
// Host controller model that drives serial command frames on the link.
`timescale 1ns/1ns
`default_nettype none
module fcpr_host (
  // Serial link
  output var  logic link_sclk,
  output var  logic link_cs_n,
  output var  logic link_din,
  input  wire logic link_dout
);
  // The link idles with the clock parked low and the frame deselected.
  initial begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_din  = 1'b0;
  end

  // Shifts out nt bits MSB first, then clocks in nr read bits.
  task automatic frame(input logic [95:0] tx, input int nt,
                       input int nr, output logic [63:0] rx);
    rx = '0;
    link_cs_n = 1'b0;
    for (int i = 0; i < nt + nr; i++) begin
      // Read phase toggles the unused data line every bit.
      link_din = (i < nt) ? tx[nt-1-i] : ~link_din;
      #40 link_sclk = 1'b1;
      if (i >= nt) begin
        rx = {rx[62:0], link_dout};
      end
      #40 link_sclk = 1'b0;
    end
    link_din = ~link_din;
    #40 link_cs_n = 1'b1;
    #160;
  endtask
endmodule
`default_nettype wire

// ===== test/fcpr_regs_assertions.sv
// Port-level assertions for the configuration and protection registers.
`timescale 1ns/1ns
`default_nettype none
module fcpr_regs_checker
  import fcpr_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        factory_erase,
  // Serial link
  input wire logic        link_sclk,
  input wire logic        link_cs_n,
  input wire logic        link_din,
  input wire logic        link_dout,
  input wire logic        link_dout_oe,
  // Program and erase gate
  input wire logic [23:0] pe_addr,
  input wire logic        pe_blocked,
  // Settings in effect
  input wire fcpr_proto_t proto_mode,
  input wire logic        dtr_mode,
  input wire logic        data_line_3_hold_en,
  input wire logic [2:0]  drive_code,
  input wire logic        nv_lock_writable,
  input wire logic        pwd_prot_on
);
  // Every check samples on the system clock and rests during reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Leaving reset shows the default protocol, rate, hold and drive.
  reset_defaults_a: assert property ($fell(rst) |->
    proto_mode == PROTO_EXT && !dtr_mode && data_line_3_hold_en &&
    drive_code == DRV_30_OHM) else $error("settings not default");
  // A reserved drive code is never taken up.
  drive_legal_a: assert property (drive_code[0])
    else $error("reserved drive code in use");
  // Settings move only three cycles after a frame has been closed.
  cfg_update_a: assert property (!$stable({proto_mode, dtr_mode,
    data_line_3_hold_en, drive_code}) |->
    $past(link_cs_n, 3) && !$past(link_cs_n, 4))
    else $error("settings changed off the frame end");
  // Password mode brings the freeze bit up locked.
  freeze_reset_a: assert property ($fell(rst) |->
    nv_lock_writable == !pwd_prot_on) else $error("freeze reset wrong");
  // Password mode is permanent short of a factory erase.
  pwd_sticky_a: assert property (pwd_prot_on && !factory_erase |=>
    pwd_prot_on) else $error("password mode dropped");
  // In password mode the freeze bit rises only after a command.
  freeze_rise_a: assert property ($rose(nv_lock_writable) &&
    pwd_prot_on |-> $past(link_cs_n, 3) && !$past(link_cs_n, 4))
    else $error("freeze rose");
  // The freeze bit falls only after a completed command.
  freeze_fall_a: assert property ($fell(nv_lock_writable) |->
    $past(link_cs_n, 3) && !$past(link_cs_n, 4))
    else $error("freeze fell off the frame end");
  // The gate follows the address, a reset or a lock change after a frame.
  gate_cause_a: assert property (!$stable(pe_blocked) |->
    $past(pe_addr) != $past(pe_addr, 2) || $past(rst, 2) ||
    $past(factory_erase, 2) ||
    $past(link_cs_n, 4) && !$past(link_cs_n, 5))
    else $error("gate changed without cause");
  // Read data and blocked sectors are both exercised.
  cover property (link_dout_oe && link_dout);
  cover property (pe_blocked);
endmodule
bind fcpr_regs fcpr_regs_checker u_chk (.ref_clk, .rst, .factory_erase,
  .link_sclk, .link_cs_n, .link_din, .link_dout, .link_dout_oe, .pe_addr,
  .pe_blocked, .proto_mode, .dtr_mode, .data_line_3_hold_en, .drive_code,
  .nv_lock_writable, .pwd_prot_on);
`default_nettype wire

// ===== test/test_fcpr_regs.sv
// Self-checking bench for the configuration and protection registers.
`timescale 1ns/1ns
`default_nettype none
module test_fcpr_regs
  import fcpr_pkg::*;
;
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  logic        ref_clk;
  logic        rst;
  logic        factory_erase;
  logic        link_sclk;
  logic        link_cs_n;
  logic        link_din;
  logic        link_dout;
  logic        link_dout_oe;
  logic [23:0] pe_addr;
  logic        pe_blocked;
  fcpr_proto_t proto_mode;
  logic        dtr_mode;
  logic        data_line_3_hold_en;
  logic [2:0]  drive_code;
  logic        nv_lock_writable;
  logic        pwd_prot_on;
  logic [63:0] rx;
  logic [7:0]  ev;
  logic [7:0]  wv [8] = '{8'h7F, 8'hBF, 8'h3F, 8'hD0, 8'hE9, 8'hFB,
                          8'hFD, 8'hF2};
  int          failures;
  int          checks;
  int          cycles;

  // Design and host model share the serial link.
  fcpr_regs u_dut (.ref_clk, .rst, .factory_erase, .link_sclk, .link_cs_n,
    .link_din, .link_dout, .link_dout_oe, .pe_addr, .pe_blocked,
    .proto_mode, .dtr_mode, .data_line_3_hold_en, .drive_code,
    .nv_lock_writable, .pwd_prot_on);
  fcpr_host u_host (.link_sclk, .link_cs_n, .link_din, .link_dout);

  // System clock and a cycle ceiling against hangs.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 50000) begin
      failures = failures + 1;
      results();
    end
  end

  // Compares a seen value with its expectation.
  task automatic chk(input string nm, input logic [63:0] s,
                     input logic [63:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Runs one frame and lets the command settle.
  task automatic cmd(input logic [95:0] tx, input int nt, input int nr);
    u_host.frame(tx, nt, nr, rx);
    repeat (10) @(negedge ref_clk);
  endtask

  // Short read with a dummy byte, then a comparison.
  task automatic rd(input string nm, input logic [7:0] op, input int nr,
                    input logic [63:0] e);
    cmd({op, 8'h00}, 16, nr);
    chk(nm, rx, e);
  endtask

  // Presents an address to the program and erase gate.
  task automatic blk(input logic [23:0] a, input logic e);
    pe_addr = a;
    repeat (2) @(negedge ref_clk);
    chk("pe_blocked", pe_blocked, e);
  endtask

  // Checks the settings at the outputs, then the register itself.
  task automatic cfg_chk();
    fcpr_proto_t p;
    p = PROTO_EXT;
    if (!ev[6]) p = PROTO_DUAL;
    if (!ev[7]) p = PROTO_QUAD;
    chk("proto_mode", proto_mode, p);
    chk("dtr_mode", dtr_mode, !ev[5]);
    chk("hold_en", data_line_3_hold_en, ev[4]);
    chk("drive_code", drive_code, ev[2:0]);
    rd("vcfg", OP_RD_VCFG, 8, ev);
  endtask

  // Writes the configuration and works out what should follow.
  task automatic wcfg(input logic [7:0] w);
    cmd({OP_WR_VCFG, w}, 16, 0);
    ev = {w[7:4], 1'b1, w[0] ? w[2:0] : ev[2:0]};
    cfg_chk();
  endtask

  // Holds reset long enough and releases it between frames.
  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  // Prints the verdict and ends the run.
  task automatic results();
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence of command scenarios.
  initial begin
    ref_clk = 1'b0;
    factory_erase = 1'b1;
    pe_addr = '0;
    failures = 0;
    checks = 0;
    cycles = 0;
    do_reset();
    factory_erase = 1'b0;
    ev = VCFG_RST;
    cfg_chk();
    rd("freeze", OP_RD_FRZ, 8, 8'h01);
    rd("protection", OP_RD_PROT, 16, PROT_RST);
    foreach (wv[i]) wcfg(wv[i]);
    wcfg(8'h1F);
    cmd({OP_RESCUE}, 8, 0);
    ev[7:5] = 3'h7;
    cfg_chk();
    wcfg(8'h1F);
    cmd({OP_SOFT_RST}, 8, 0);
    ev = VCFG_RST;
    cfg_chk();
    wcfg(8'h3F);
    do_reset();
    ev = VCFG_RST;
    cfg_chk();
    cmd({OP_WR_NV, 24'h03_0000}, 32, 0);
    blk(24'h03_0000, 1'b1);
    blk(24'h04_0000, 1'b0);
    cmd({OP_RD_NV, 24'h03_0000, 8'h00}, 40, 8);
    chk("nv_lock", rx, 8'h00);
    cmd({OP_WR_FRZ}, 8, 0);
    rd("freeze", OP_RD_FRZ, 8, 8'h00);
    cmd({OP_ER_NV}, 8, 0);
    blk(24'h03_0000, 1'b1);
    cmd({OP_UNLOCK, 64'h0}, 72, 0);
    chk("writable", nv_lock_writable, 1'b1);
    cmd({OP_ER_NV}, 8, 0);
    blk(24'h03_0000, 1'b0);
    cmd({OP_WR_VL, 24'h00_2000, 8'h01}, 40, 0);
    blk(24'h00_2000, 1'b1);
    blk(24'h00_3000, 1'b0);
    cmd({OP_RD_VL, 24'h00_2000, 8'h00}, 40, 8);
    chk("vl_lock", rx, 8'h01);
    cmd({OP_WR_VL, 24'h05_0000, 8'h03}, 40, 0);
    cmd({OP_WR_VL, 24'h05_0000, 8'h00}, 40, 0);
    blk(24'h05_8000, 1'b1);
    do_reset();
    blk(24'h05_8000, 1'b0);
    blk(24'h00_2000, 1'b0);
    cmd({OP_WR_PROT, 16'hFFF9}, 24, 0);
    rd("protection", OP_RD_PROT, 16, PROT_RST);
    cmd({OP_WR_PROT, 16'h0005}, 24, 0);
    rd("protection", OP_RD_PROT, 16, 16'hFFFD);
    cmd({OP_WR_PROT, 16'hFFFB}, 24, 0);
    rd("protection", OP_RD_PROT, 16, 16'hFFFD);
    chk("pwd_prot_on", pwd_prot_on, 1'b0);
    factory_erase = 1'b1;
    @(negedge ref_clk);
    factory_erase = 1'b0;
    @(negedge ref_clk);
    cmd({OP_WR_PWD, KEY}, 72, 0);
    rd("password", OP_RD_PWD, 64, KEY);
    cmd({OP_WR_PROT, 16'hFFFB}, 24, 0);
    chk("pwd_prot_on", pwd_prot_on, 1'b1);
    rd("protection", OP_RD_PROT, 16, 16'hFFFB);
    rd("password", OP_RD_PWD, 64, PWD_RST);
    cmd({OP_WR_PWD, ~KEY}, 72, 0);
    cmd({OP_WR_PROT, 16'hFFFD}, 24, 0);
    rd("protection", OP_RD_PROT, 16, 16'hFFFB);
    do_reset();
    chk("writable", nv_lock_writable, 1'b0);
    cmd({OP_WR_NV, 24'h07_0000}, 32, 0);
    blk(24'h07_0000, 1'b0);
    cmd({OP_UNLOCK, ~KEY}, 72, 0);
    chk("writable", nv_lock_writable, 1'b0);
    cmd({OP_UNLOCK, KEY}, 72, 0);
    chk("writable", nv_lock_writable, 1'b1);
    cmd({OP_WR_NV, 24'h07_0000}, 32, 0);
    blk(24'h07_0000, 1'b1);
    results();
  end
endmodule
`default_nettype wire
